/* pec_pkg.sv */
// Shared constants for the port edge change interrupt block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package pec_pkg;
	localparam int PEC_AW = 8;
	localparam int PEC_DW = 32;
	localparam int PEC_PIN_CNT = 4;
	localparam int PEC_PIN_LSB = 4;
	localparam int PEC_PIN_MSB = 7;
	localparam int PEC_SYNC_STAGES = 2;

	localparam logic [7:0] PEC_OFS_RISE_EN = 8'h00;
	localparam logic [7:0] PEC_OFS_FALL_EN = 8'h04;
	localparam logic [7:0] PEC_OFS_FLAGS = 8'h08;
	localparam logic [7:0] PEC_OFS_IRQ_STATUS = 8'h0C;
	localparam logic [7:0] PEC_OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] PEC_OFS_PIN_LEVEL = 8'h14;

	localparam int PEC_SUMMARY_BIT = 0;

	localparam logic [3:0] PEC_RST_RISE_EN = 4'h0;
	localparam logic [3:0] PEC_RST_FALL_EN = 4'h0;
	localparam logic [3:0] PEC_RST_FLAGS = 4'h0;
	localparam logic PEC_RST_SUMMARY = 1'b0;
	localparam logic PEC_RST_MASK = 1'b0;
	localparam logic [31:0] PEC_RD_ZERO = 32'h0000_0000;
endpackage : pec_pkg

/* pec_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the destination clock is clk; only stage two is read.
`timescale 1ns/1ns
module pec_sync #(
	parameter int W = 4
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [W-1:0] d, // Asynchronous input
	output logic [W-1:0] q // Synchronised level
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule : pec_sync

/* pec_edge_cell.sv */
// Edge qualifier for one monitored pin.
// Assumes cur and prev are synchronised samples one clock apart.
`timescale 1ns/1ns
module pec_edge_cell (
	input wire logic cur, // Current synchronised sample
	input wire logic prev, // Previous synchronised sample
	input wire logic armed, // Previous sample is meaningful
	input wire logic rise_en, // Rising edge detection enabled
	input wire logic fall_en, // Falling edge detection enabled
	output logic set_flag // Qualified edge, one-cycle pulse
);
	logic rise;
	logic fall;

	assign rise = cur & ~prev;
	assign fall = ~cur & prev;
	// Both enables set catches either direction
	assign set_flag = armed & ((rise & rise_en) | (fall & fall_en));
endmodule : pec_edge_cell

/* pec_top.sv */
// Edge change interrupt logic for port pins 7 to 4, Wishbone slave.
// Assumes pins are asynchronous and the bus master is classic Wishbone.
`timescale 1ns/1ns
// Notes on behaviour
// - Rising edge on pin 7..4 is an event when its rise enable is 1.
// - Falling edge on pin 7..4 is an event when its fall enable is 1.
// - A disabled polarity is ignored and never sets a flag.
// - An enabled edge sets that pin's change flag.
// - Any flag set by hardware also sets the shared summary flag.
// - Flags hold until software writes 0; a same-cycle set wins.
// - Bits 3..0 of enable and flag registers read 0, ignore writes.
module pec_top
	import pec_pkg::*;
(
	input wire logic clk, // System clock, 50 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [PEC_AW-1:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte lane selects
	input wire logic [PEC_DW-1:0] wb_dat_i, // Write data
	output logic [PEC_DW-1:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic [PEC_PIN_CNT-1:0] monitored_port_pin, // Pins 7..4
	output logic irq // Level interrupt
);
	logic ack_q;
	logic [PEC_DW-1:0] rdat_q;
	logic [PEC_DW-1:0] rdat_d;
	logic [PEC_PIN_CNT-1:0] rise_en_q;
	logic [PEC_PIN_CNT-1:0] fall_en_q;
	logic [PEC_PIN_CNT-1:0] flags_q;
	logic [PEC_PIN_CNT-1:0] flags_d;
	logic summary_q;
	logic mask_q;
	logic armed_q;
	logic [PEC_PIN_CNT-1:0] pin_s;
	logic [PEC_PIN_CNT-1:0] pin_prev_q;
	logic [PEC_PIN_CNT-1:0] hw_set;
	logic req;
	logic wr_lo;
	logic rise_en_wr;
	logic fall_en_wr;
	logic flag_wr;
	logic status_wr;
	logic mask_wr;
	logic [PEC_PIN_CNT-1:0] wr_nib;

	assign req = wb_cyc_i & wb_stb_i;
	// Writes land at the same edge the master samples ack
	assign wr_lo = req & wb_we_i & ack_q & wb_sel_i[0];
	assign wr_nib = wb_dat_i[PEC_PIN_MSB:PEC_PIN_LSB];
	assign rise_en_wr = wr_lo & (wb_adr_i == PEC_OFS_RISE_EN);
	assign fall_en_wr = wr_lo & (wb_adr_i == PEC_OFS_FALL_EN);
	assign flag_wr = wr_lo & (wb_adr_i == PEC_OFS_FLAGS);
	assign status_wr = wr_lo & (wb_adr_i == PEC_OFS_IRQ_STATUS);
	assign mask_wr = wr_lo & (wb_adr_i == PEC_OFS_IRQ_MASK);

	// One wait state: ack one cycle after the request, for one cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Unmapped addresses answer with zero data
	always_comb begin
		rdat_d = PEC_RD_ZERO;
		case (wb_adr_i)
			PEC_OFS_RISE_EN: begin
				rdat_d[PEC_PIN_MSB:PEC_PIN_LSB] = rise_en_q;
			end
			PEC_OFS_FALL_EN: begin
				rdat_d[PEC_PIN_MSB:PEC_PIN_LSB] = fall_en_q;
			end
			PEC_OFS_FLAGS: begin
				rdat_d[PEC_PIN_MSB:PEC_PIN_LSB] = flags_q;
			end
			PEC_OFS_IRQ_STATUS: begin
				rdat_d[PEC_SUMMARY_BIT] = summary_q;
			end
			PEC_OFS_IRQ_MASK: begin
				rdat_d[PEC_SUMMARY_BIT] = mask_q;
			end
			PEC_OFS_PIN_LEVEL: begin
				rdat_d[PEC_PIN_MSB:PEC_PIN_LSB] = pin_s;
			end
			default: begin
				rdat_d = PEC_RD_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdat_q <= PEC_RD_ZERO;
		end else if (req & ~ack_q & ~wb_we_i) begin
			rdat_q <= rdat_d;
		end else if (ack_q) begin
			rdat_q <= PEC_RD_ZERO;
		end
	end

	// Only the upper nibble is stored; low bits cannot hold a write
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rise_en_q <= PEC_RST_RISE_EN;
		end else if (rise_en_wr) begin
			rise_en_q <= wr_nib;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fall_en_q <= PEC_RST_FALL_EN;
		end else if (fall_en_wr) begin
			fall_en_q <= wr_nib;
		end
	end

	pec_sync #(
		.W(PEC_PIN_CNT)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(monitored_port_pin),
		.q(pin_s)
	);

	// First sample after reset only primes the history; a pin high in reset still shows as a rise two edges after release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_prev_q <= '0;
			armed_q <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
			armed_q <= 1'b1;
		end
	end

	for (genvar i = 0; i < PEC_PIN_CNT; i++) begin : g_pin
		pec_edge_cell u_cell (
			.cur(pin_s[i]),
			.prev(pin_prev_q[i]),
			.armed(armed_q),
			.rise_en(rise_en_q[i]),
			.fall_en(fall_en_q[i]),
			.set_flag(hw_set[i])
		);
	end

	// Writing 0 clears, writing 1 keeps; hardware set wins
	always_comb begin
		flags_d = flags_q;
		if (flag_wr) begin
			flags_d = flags_q & wr_nib;
		end
		flags_d = flags_d | hw_set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_q <= PEC_RST_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Summary is write-one-to-clear; a new edge beats the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			summary_q <= PEC_RST_SUMMARY;
		end else if (|hw_set) begin
			summary_q <= 1'b1;
		end else if (status_wr & wb_dat_i[PEC_SUMMARY_BIT]) begin
			summary_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask_q <= PEC_RST_MASK;
		end else if (mask_wr) begin
			mask_q <= wb_dat_i[PEC_SUMMARY_BIT];
		end
	end

	assign irq = summary_q & mask_q;

	// Checks
	logic [PEC_PIN_CNT-1:0] rise_hit;
	logic [PEC_PIN_CNT-1:0] fall_hit;

	assign rise_hit = pin_s & ~pin_prev_q & rise_en_q & {PEC_PIN_CNT{armed_q}};
	assign fall_hit = ~pin_s & pin_prev_q & fall_en_q & {PEC_PIN_CNT{armed_q}};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_RISE_SETS_FLAG: assert property (
		(rise_hit != 4'h0) |=> ((flags_q & $past(rise_hit)) == $past(rise_hit))
	) else $error("enabled rising edge did not set its flag");

	AST_FALL_SETS_FLAG: assert property (
		(fall_hit != 4'h0) |=> ((flags_q & $past(fall_hit)) == $past(fall_hit))
	) else $error("enabled falling edge did not set its flag");

	AST_DISABLED_IGNORED: assert property (
		(hw_set & ~(rise_hit | fall_hit)) == 4'h0
	) else $error("flag set by a disabled edge polarity");

	AST_FLAG_RISE_CAUSE: assert property (
		((flags_q & ~$past(flags_q)) & ~$past(hw_set)) == 4'h0
	) else $error("flag rose without a qualified edge");

	AST_SUMMARY_FOLLOWS: assert property (
		(hw_set != 4'h0) |=> summary_q
	) else $error("summary flag missed an edge event");

	AST_FLAG_HOLDS: assert property (
		(($past(flags_q) & ~flags_q) != 4'h0) |-> $past(flag_wr)
	) else $error("flag cleared without a software write");

	AST_SET_BEATS_CLEAR: assert property (
		(flag_wr && hw_set != 4'h0)
		|=> ((flags_q & $past(hw_set)) == $past(hw_set))
	) else $error("software clear beat a hardware set");

	AST_LOW_BITS_ZERO: assert property (
		(wb_ack_o && !wb_we_i) |-> (wb_dat_o[3:0] == 4'h0
			|| $past(wb_adr_i) > PEC_OFS_FLAGS)
	) else $error("unimplemented low bits read nonzero");

	AST_SYNC_DEPTH: assert property (
		$past(armed_q) |-> (pin_s == $past(monitored_port_pin, 2))
	) else $error("pin sample not two stages behind pin");

	// Bus side: one wait state, ack for one cycle, data only with ack
	AST_ACK_ANSWERS: assert property (
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o
	) else $error("request not acknowledged after one wait state");

	AST_ACK_ONE_CYCLE: assert property (
		wb_ack_o |=> !wb_ack_o
	) else $error("acknowledge stood longer than one cycle");

	AST_RDATA_IDLE_ZERO: assert property (
		!wb_ack_o |-> (wb_dat_o == PEC_RD_ZERO)
	) else $error("read data nonzero outside acknowledge");

	AST_UNMAPPED_READ_ZERO: assert property (
		(wb_ack_o && !wb_we_i && wb_adr_i > PEC_OFS_PIN_LEVEL)
		|-> (wb_dat_o == PEC_RD_ZERO)
	) else $error("unmapped address read nonzero");

	// All registers sit in lane zero; without sel[0] nothing changes
	AST_NO_SEL_NO_WRITE: assert property (
		(wb_ack_o && wb_we_i && !wb_sel_i[0])
		|=> ($stable(rise_en_q) && $stable(fall_en_q)
			&& $stable(mask_q))
	) else $error("write without lane zero changed a register");

	AST_FLAG_CLEAR_LANDS: assert property (
		(flag_wr && hw_set == 4'h0)
		|=> (flags_q == ($past(flags_q) & $past(wr_nib)))
	) else $error("flag clear by software did not land");

	AST_FLAGS_READ: assert property (
		(wb_ack_o && !wb_we_i && wb_adr_i == PEC_OFS_FLAGS)
		|-> (wb_dat_o[PEC_PIN_MSB:PEC_PIN_LSB] == $past(flags_q))
	) else $error("flag read does not match stored flags");

	// Summary clears only by a status write, and a new edge beats it
	AST_SUMMARY_CLEAR_CAUSE: assert property (
		$fell(summary_q) |-> $past(status_wr)
	) else $error("summary flag fell without a status write");

	AST_SUMMARY_SET_WINS: assert property (
		(status_wr && wb_dat_i[PEC_SUMMARY_BIT] && hw_set != 4'h0)
		|=> summary_q
	) else $error("status clear beat a new edge event");

	AST_STATUS_READ: assert property (
		(wb_ack_o && !wb_we_i && wb_adr_i == PEC_OFS_IRQ_STATUS)
		|-> (wb_dat_o[PEC_SUMMARY_BIT] == $past(summary_q))
	) else $error("status read does not match summary flag");

	AST_PIN_LEVEL_READ: assert property (
		(wb_ack_o && !wb_we_i && wb_adr_i == PEC_OFS_PIN_LEVEL)
		|-> (wb_dat_o[PEC_PIN_MSB:PEC_PIN_LSB] == $past(pin_s))
	) else $error("pin level read is not the synchronised sample");

	COV_RISE: cover property (rise_hit != 4'h0 ##1 irq);
	COV_FALL: cover property (fall_hit != 4'h0);
	COV_SET_AND_CLEAR: cover property (flag_wr && hw_set != 4'h0);
	COV_BOTH_EDGES: cover property ((rise_hit & fall_en_q) != 4'h0);
	COV_STATUS_RACE: cover property (status_wr && hw_set != 4'h0);
endmodule : pec_top

/* pec_pin_drv.sv */
// Model of the outside circuit that drives the monitored pins 7..4.
// Assumes pins change only just after a rising clock edge.
`timescale 1ns/1ns
module pec_pin_drv (
	input wire logic clk, // System clock
	output logic [3:0] pins // Pin levels, bit0 is pin 4
);
	initial pins = 4'h0;

	// Hold each level long enough to pass sync and edge logic
	task set(input logic [3:0] v);
		@(posedge clk);
		pins <= v;
		repeat (6) @(posedge clk);
	endtask : set
endmodule : pec_pin_drv

/* tb_port_edge_change_interrupt.sv */
// Self-checking bench for the edge change block over Wishbone.
// Assumes one-cycle ack and a pin driver model beside the block.
`timescale 1ns/1ns
module tb_port_edge_change_interrupt;
	import pec_pkg::*;
	logic clk, rst_n, cyc, stb, we, ack, irq;
	logic [7:0] adr;
	logic [31:0] dat, rdat, r;
	logic [3:0] pins;
	logic [3:0] sel;
	int error_cnt = 0;
	int n_compared = 0;

	pec_top uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .monitored_port_pin(pins),
		.irq(irq));
	pec_pin_drv pdrv (.clk(clk), .pins(pins));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task close_out;
		$display("compared %0d, errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Holds the request until ack is sampled high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd

	task irq_is(input logic exp);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask : irq_is

	initial begin
		#100000;
		error_cnt++;
		$display("ERROR %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'hF;
		adr = 8'h00;
		dat = 32'h0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
		wr(PEC_OFS_RISE_EN, 32'hFF);
		rd(PEC_OFS_RISE_EN, 32'hF0);
		wr(PEC_OFS_FALL_EN, 32'hFF);
		rd(PEC_OFS_FALL_EN, 32'hF0);
		wr(PEC_OFS_FLAGS, 32'hFF);
		rd(PEC_OFS_FLAGS, 32'h0);
		rd(8'h20, 32'h0);
		$display("test 1 done");
		wr(PEC_OFS_FALL_EN, 32'h0);
		pdrv.set(4'hF);
		rd(PEC_OFS_FLAGS, 32'hF0);
		rd(PEC_OFS_IRQ_STATUS, 32'h1);
		rd(PEC_OFS_PIN_LEVEL, 32'hF0);
		wr(PEC_OFS_PIN_LEVEL, 32'h0);
		rd(PEC_OFS_PIN_LEVEL, 32'hF0);
		wr(PEC_OFS_FLAGS, 32'h70);
		rd(PEC_OFS_FLAGS, 32'h70);
		wr(PEC_OFS_FLAGS, 32'h0);
		pdrv.set(4'h0);
		rd(PEC_OFS_FLAGS, 32'h0);
		$display("test 2 done");
		wr(PEC_OFS_RISE_EN, 32'h0);
		wr(PEC_OFS_FALL_EN, 32'hF0);
		pdrv.set(4'hF);
		rd(PEC_OFS_FLAGS, 32'h0);
		pdrv.set(4'h5);
		rd(PEC_OFS_FLAGS, 32'hA0);
		$display("test 3 done");
		wr(PEC_OFS_FLAGS, 32'h0);
		wr(PEC_OFS_RISE_EN, 32'hF0);
		pdrv.set(4'h4);
		rd(PEC_OFS_FLAGS, 32'h10);
		wr(PEC_OFS_FLAGS, 32'h0);
		pdrv.set(4'h5);
		rd(PEC_OFS_FLAGS, 32'h10);
		$display("test 4 done");
		irq_is(1'b0);
		wr(PEC_OFS_IRQ_MASK, 32'h1);
		rd(PEC_OFS_IRQ_MASK, 32'h1);
		irq_is(1'b1);
		wr(PEC_OFS_IRQ_STATUS, 32'h1);
		rd(PEC_OFS_IRQ_STATUS, 32'h0);
		irq_is(1'b0);
		$display("test 5 done");
		// Clear write lands on the very edge that sets pin 7's flag
		fork
			pdrv.set(4'hD);
			begin
				@(posedge clk);
				wr(PEC_OFS_FLAGS, 32'h0);
			end
		join
		rd(PEC_OFS_FLAGS, 32'h80);
		fork
			pdrv.set(4'h5);
			begin
				@(posedge clk);
				wr(PEC_OFS_IRQ_STATUS, 32'h1);
			end
		join
		rd(PEC_OFS_IRQ_STATUS, 32'h1);
		irq_is(1'b1);
		sel <= 4'hE;
		wr(PEC_OFS_RISE_EN, 32'h0);
		sel <= 4'hF;
		rd(PEC_OFS_RISE_EN, 32'hF0);
		$display("test 6 done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
		rd(PEC_OFS_PIN_LEVEL, 32'h50);
		irq_is(1'b0);
		$display("test 7 done");
		close_out();
	end
endmodule : tb_port_edge_change_interrupt
